// ---- hw/pgd_datapath.sv ----
// Purpose: planar graphics write/read datapath with its register file
// Assumes: synchronous host strobes, one request per cycle per port
// Notes:   reads answer RD_LAT edges after being taken
// Functional notes
// [RULE1] Two-bit operation combines source with latches: pass, AND, OR, XOR.
// [RULE2] Write mode 0 rotates host data right by the rotate count.
// [RULE3] Rotation is circular; bits leaving the bottom re-enter at the top.
// [RULE4] Read-map field picks the map for plain reads, not for compares.
// [RULE5] In odd/even modes map values 0,1 pick maps 0/1, values 2,3 maps 2/3.
// [RULE6] 256-colour bit selects that load format, else the shift-format bit.
// [RULE7] Shift format normal or interleaved; most significant bit goes first.
// [RULE8] Odd/even access bit: even addresses to maps 0/2, odd to maps 1/3.
// [RULE9] Read-type bit one returns the colour compare, zero the chosen map.
// [RULE10] Plain map selection ignored when the sequencer chain-four bit is set.
// [RULE11] Mode 0 enabled maps take set/reset value, others the rotated data.
// [RULE12] Mode 1 writes all 32 latch bits, one latch byte per map.
// [RULE13] Every host memory read loads the four latches.
// [RULE14] Mode 2 replicates data bits 3..0 over maps 3..0, then bit mask.
// [RULE15] Mode 3 writes each map's set/reset bit, ignoring the enables.
// [RULE16] Mode 3 mask is rotated host data ANDed with the bit mask.
// [RULE17] Window field maps memory to 128K, 64K or one of two 32K windows.
// [RULE18] Chain bit swaps address bit 0 for a high bit and steers maps.
// [RULE19] Software keeps the graphics bit equal to the attribute mode bit.
// [RULE20] Per-map include bits choose which maps take part in compares.
// [RULE21] Bit mask one lets new data in, zero keeps the latched bit.
// [RULE22] Software reads a byte, sets the mask, then writes the same byte.
// [RULE23] Compare gives one where all included maps match their colour bits.
// [RULE24] Mode 0 set/reset enable replaces rotated data by set/reset bit.
// [RULE25] Registers reached by writing an index, then the data port.
// [RULE26] Logic operation applies before the bit mask merges with latches.
// [RULE27] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module pgd_datapath
    import pgd_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    input  wire pgd_pkg::pgd_io_req_s  io_req_in,
    output logic [7:0]                 io_rdata_out,
    input  wire pgd_pkg::pgd_mem_req_s mem_req_in,
    output logic                       mem_rvalid_out,
    output logic [7:0]                 mem_rdata_out,
    input  wire logic                  seq_chain4_in,
    input  wire logic [3:0]            plane_wr_en_in,
    input  wire logic                  vid_load_in,
    input  wire logic                  vid_shift_in,
    input  wire logic [AW-1:0]         vid_addr_in,
    output logic [3:0]                 pixel_out,
    output logic                       pixel_256_out,
    output logic                       gfx_mode_out
);
    import pgd_pkg::*;

    typedef struct packed {
        logic [3:0]      idx;
        logic [7:0]      r_sr;
        logic [7:0]      r_esr;
        logic [7:0]      r_cmp;
        logic [7:0]      r_rot;
        logic [7:0]      r_rmap;
        logic [7:0]      r_mode;
        logic [7:0]      r_misc;
        logic [7:0]      r_dc;
        logic [7:0]      r_mask;
        logic [7:0]      io_rdata;
        logic [31:0]     latch;
        logic            rd_p1;
        logic            rd_cmp;
        logic [1:0]      rd_map;
        logic            rvalid;
        logic [7:0]      rdata;
        logic            vld_p1;
        logic [3:0][7:0] sr;
        logic [3:0]      pix;
    } pgd_state_s;

    pgd_state_s st_reg;
    pgd_state_s st_next;

    logic [31:0]     q_host;
    logic [31:0]     q_vid;
    logic [AW-1:0]   maddr;
    logic [3:0]      we;
    logic [31:0]     wdata_all;
    logic [19:0]     win_lo;
    logic [19:0]     win_hi;
    logic [19:0]     off;
    logic            hit;
    logic            host_a0;
    logic            chain_oe;
    logic            steer_oe;
    logic [3:0]      plane_sel;
    logic [1:0]      rd_map;
    logic [15:0]     rot_wide;
    logic [7:0]      rot;
    logic [7:0]      eff_mask;
    logic [7:0]      cmp_res;
    pgd_wmode_e      wmode;
    pgd_op_e         op;
    logic [3:0][7:0] fmt_norm;
    logic [3:0][7:0] fmt_il;
    logic [3:0][7:0] fmt_256;

    assign wmode    = pgd_wmode_e'(st_reg.r_mode[WM_LSB +: 2]);
    assign op       = pgd_op_e'(st_reg.r_rot[OP_LSB +: 2]);
    assign host_a0  = mem_req_in.addr[0];
    assign chain_oe = st_reg.r_misc[MISC_OE];
    assign steer_oe = st_reg.r_misc[MISC_OE] | st_reg.r_mode[MODE_OE];

    // Window decode from the map field
    always_comb begin
        case (pgd_win_e'(st_reg.r_misc[MISC_WIN +: 2]))
            PGD_WIN_128K: begin
                win_lo = WIN_A0000; // RULE17
                win_hi = WIN_C0000;
            end
            PGD_WIN_64K: begin
                win_lo = WIN_A0000; // RULE17
                win_hi = WIN_B0000;
            end
            PGD_WIN_MONO: begin
                win_lo = WIN_B0000; // RULE17
                win_hi = WIN_B8000;
            end
            default: begin
                win_lo = WIN_B8000; // RULE17
                win_hi = WIN_C0000;
            end
        endcase
    end

    assign hit = (mem_req_in.addr >= win_lo) && (mem_req_in.addr < win_hi);
    assign off = mem_req_in.addr - win_lo;

    // Map address and map steering; chain-four wins over odd/even
    always_comb begin
        if (seq_chain4_in) begin
            maddr     = off[AW+1:2];
            plane_sel = 4'h1 << off[1:0];
            rd_map    = off[1:0]; // RULE10
        end else if (steer_oe) begin
            // Address bit 0 replaced only when the chain bit asks for it
            maddr     = chain_oe ? {off[AW-1:1], off[AW]} // RULE18
                                 : off[AW-1:0];
            plane_sel = host_a0 ? 4'ha : 4'h5; // RULE8 RULE18
            rd_map    = {st_reg.r_rmap[1], host_a0}; // RULE5
        end else begin
            maddr     = off[AW-1:0]; // RULE18
            plane_sel = 4'hf;
            rd_map    = st_reg.r_rmap[1:0]; // RULE4
        end
    end

    assign we = (mem_req_in.wr && hit) ? (plane_sel & plane_wr_en_in)
                                       : 4'h0;

    // Circular right rotate by doubling the byte
    assign rot_wide = {mem_req_in.wdata, mem_req_in.wdata}
                      >> st_reg.r_rot[ROT_LSB +: 3]; // RULE2 RULE3
    assign rot      = rot_wide[7:0]; // RULE3
    assign eff_mask = (wmode == PGD_WM3) ? (rot & st_reg.r_mask) // RULE16
                                         : st_reg.r_mask;

    // Per-map write data and per-lane shift-register load formats
    for (genvar i = 0; i < 4; i++) begin : g_lane
        logic [7:0] src;
        logic [7:0] alu;
        logic [7:0] lat;
        assign lat = st_reg.latch[8*i +: 8];
        always_comb begin
            case (wmode)
                PGD_WM0: src = st_reg.r_esr[i] ? {8{st_reg.r_sr[i]}}
                                               : rot; // RULE11 RULE24
                PGD_WM2: src = {8{mem_req_in.wdata[i]}}; // RULE14
                default: src = {8{st_reg.r_sr[i]}}; // RULE15
            endcase
            case (op)
                PGD_OP_PASS: alu = src; // RULE1
                PGD_OP_AND:  alu = src & lat; // RULE1
                PGD_OP_OR:   alu = src | lat; // RULE1
                default:     alu = src ^ lat; // RULE1
            endcase
        end
        // Operation first, then the mask merges with latched bits
        assign wdata_all[8*i +: 8] = (wmode == PGD_WM1) ? lat // RULE12
            : ((alu & eff_mask) | (lat & ~eff_mask)); // RULE21 RULE26
        // Colour compare bit per position across included maps
        assign cmp_res[2*i] = &(~st_reg.r_dc[3:0] // RULE20 RULE23
            | ~({q_host[24+2*i], q_host[16+2*i], q_host[8+2*i],
                 q_host[2*i]} ^ st_reg.r_cmp[3:0]));
        assign cmp_res[2*i+1] = &(~st_reg.r_dc[3:0] // RULE20 RULE23
            | ~({q_host[25+2*i], q_host[17+2*i], q_host[9+2*i],
                 q_host[2*i+1]} ^ st_reg.r_cmp[3:0]));
        assign fmt_norm[i] = q_vid[8*i +: 8]; // RULE7
        for (genvar n = 0; n < 4; n++) begin : g_bit
            // Interleave: even/odd bits of a map pair per register
            assign fmt_il[i][7-n] = q_vid[8*(i/2*2) + 6 + i%2 - 2*n]; // RULE7
            assign fmt_il[i][3-n] = q_vid[8*(i/2*2+1) + 6 + i%2 - 2*n];
            // 256 colour: high then low nibble of each map byte
            assign fmt_256[i][7-2*n] = q_vid[8*n + 4 + i]; // RULE6
            assign fmt_256[i][6-2*n] = q_vid[8*n + i];
        end
    end

    pgd_plane_mem #(
        .AW          (AW)
    ) u_mem (
        .mclk_in     (mclk_in),
        .a_addr_in   (maddr),
        .a_we_in     (we),
        .a_wdata_in  (wdata_all),
        .a_rdata_out (q_host),
        .b_addr_in   (vid_addr_in),
        .b_rdata_out (q_vid)
    );

    // Next state: register port, host read pipe, video shifter
    always_comb begin
        st_next        = st_reg;
        st_next.rd_p1  = 1'b0;
        st_next.rvalid = 1'b0;
        st_next.vld_p1 = vid_load_in;
        // Index then data port access
        if (io_req_in.wr && !io_req_in.sel) begin
            st_next.idx = io_req_in.wdata[3:0]; // RULE25
        end else if (io_req_in.wr) begin
            if (st_reg.idx == IDX_SET_RST) begin
                st_next.r_sr = io_req_in.wdata & WMSK_NIB; // RULE27
            end else if (st_reg.idx == IDX_EN_SR) begin
                st_next.r_esr = io_req_in.wdata & WMSK_NIB; // RULE27
            end else if (st_reg.idx == IDX_CMP) begin
                st_next.r_cmp = io_req_in.wdata & WMSK_NIB; // RULE27
            end else if (st_reg.idx == IDX_ROT) begin
                st_next.r_rot = io_req_in.wdata & WMSK_ROT; // RULE27
            end else if (st_reg.idx == IDX_RMAP) begin
                st_next.r_rmap = io_req_in.wdata & WMSK_RMAP; // RULE27
            end else if (st_reg.idx == IDX_MODE) begin
                st_next.r_mode = io_req_in.wdata & WMSK_MODE; // RULE27
            end else if (st_reg.idx == IDX_MISC) begin
                st_next.r_misc = io_req_in.wdata & WMSK_NIB; // RULE27
            end else if (st_reg.idx == IDX_DC) begin
                st_next.r_dc = io_req_in.wdata & WMSK_NIB; // RULE27
            end else if (st_reg.idx == IDX_MASK) begin
                st_next.r_mask = io_req_in.wdata & WMSK_FULL;
            end
        end
        // Read data captured on the read strobe; unused indices read zero
        if (io_req_in.rd && !io_req_in.sel) begin
            st_next.io_rdata = {4'h0, st_reg.idx}; // RULE27
        end else if (io_req_in.rd) begin
            if (st_reg.idx == IDX_SET_RST) begin
                st_next.io_rdata = st_reg.r_sr;
            end else if (st_reg.idx == IDX_EN_SR) begin
                st_next.io_rdata = st_reg.r_esr;
            end else if (st_reg.idx == IDX_CMP) begin
                st_next.io_rdata = st_reg.r_cmp;
            end else if (st_reg.idx == IDX_ROT) begin
                st_next.io_rdata = st_reg.r_rot;
            end else if (st_reg.idx == IDX_RMAP) begin
                st_next.io_rdata = st_reg.r_rmap;
            end else if (st_reg.idx == IDX_MODE) begin
                st_next.io_rdata = st_reg.r_mode;
            end else if (st_reg.idx == IDX_MISC) begin
                st_next.io_rdata = st_reg.r_misc;
            end else if (st_reg.idx == IDX_DC) begin
                st_next.io_rdata = st_reg.r_dc;
            end else if (st_reg.idx == IDX_MASK) begin
                st_next.io_rdata = st_reg.r_mask;
            end else begin
                st_next.io_rdata = RST_REG; // RULE27
            end
        end
        // Host read: memory answers next cycle, latches load then
        if (mem_req_in.rd && hit) begin
            st_next.rd_p1  = 1'b1;
            st_next.rd_cmp = st_reg.r_mode[MODE_RDCMP]; // RULE9
            st_next.rd_map = rd_map;
        end
        if (st_reg.rd_p1) begin
            st_next.latch  = q_host; // RULE13
            st_next.rvalid = 1'b1;
            st_next.rdata  = st_reg.rd_cmp ? cmp_res // RULE9
                                           : q_host[8*st_reg.rd_map +: 8];
        end
        // Load beats shift when both land in one cycle
        if (st_reg.vld_p1) begin
            if (st_reg.r_mode[MODE_256]) begin
                st_next.sr = fmt_256; // RULE6
            end else if (st_reg.r_mode[MODE_SHIFT]) begin
                st_next.sr = fmt_il; // RULE7
            end else begin
                st_next.sr = fmt_norm; // RULE7
            end
        end else if (vid_shift_in) begin
            for (int k = 0; k < 4; k++) begin
                st_next.sr[k] = {st_reg.sr[k][6:0], 1'b0}; // RULE7
            end
        end
        for (int k = 0; k < 4; k++) begin
            st_next.pix[k] = st_next.sr[k][7]; // RULE7
        end
    end

    // Single state register; everything resets to zero
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign io_rdata_out   = st_reg.io_rdata;
    assign mem_rvalid_out = st_reg.rvalid;
    assign mem_rdata_out  = st_reg.rdata;
    assign pixel_out      = st_reg.pix;
    assign pixel_256_out  = st_reg.r_mode[MODE_256];
    assign gfx_mode_out   = st_reg.r_misc[MISC_GFX];

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_latch_load;
        mem_req_in.rd && hit |-> ##2 st_reg.latch == $past(q_host, 1);
    endproperty
    a_latch_load: assert property (p_latch_load) // RULE13
        else $error("latches not loaded by host read");

    property p_rd_answer;
        mem_req_in.rd && hit |-> !mem_rvalid_out ##1 !mem_rvalid_out
                                 ##1 mem_rvalid_out;
    endproperty
    a_rd_answer: assert property (p_rd_answer) // RULE9
        else $error("read answer not two edges after request");

    property p_mode1;
        we != 4'h0 && wmode == PGD_WM1 |-> wdata_all == st_reg.latch;
    endproperty
    a_mode1: assert property (p_mode1) // RULE12
        else $error("mode 1 write differs from latches");

    property p_mode0_rot;
        we[0] && wmode == PGD_WM0 && !st_reg.r_esr[0] && op == PGD_OP_PASS
        && st_reg.r_mask == 8'hff |-> wdata_all[7:0] == 8'((
           {8'h00, mem_req_in.wdata} >> st_reg.r_rot[2:0])
           | ({8'h00, mem_req_in.wdata} << (4'h8 - st_reg.r_rot[2:0])));
    endproperty
    a_mode0_rot: assert property (p_mode0_rot) // RULE2
        else $error("mode 0 rotation wrong");

    property p_mode2;
        we[3] && wmode == PGD_WM2 && op == PGD_OP_PASS
        && st_reg.r_mask == 8'hff |-> wdata_all[31:24]
                                    == {8{mem_req_in.wdata[3]}};
    endproperty
    a_mode2: assert property (p_mode2) // RULE14
        else $error("mode 2 replication wrong");

    property p_mode3;
        we[1] && wmode == PGD_WM3 && op == PGD_OP_PASS |->
        wdata_all[15:8] == (({8{st_reg.r_sr[1]}} & rot & st_reg.r_mask)
                            | (st_reg.latch[15:8] & ~(rot & st_reg.r_mask)));
    endproperty
    a_mode3: assert property (p_mode3) // RULE15
        else $error("mode 3 write wrong");

    property p_mask_zero;
        we != 4'h0 && st_reg.r_mask == 8'h00 && wmode != PGD_WM3
        |-> wdata_all == st_reg.latch;
    endproperty
    a_mask_zero: assert property (p_mask_zero) // RULE21
        else $error("masked bits changed");

    property p_oe_even;
        mem_req_in.wr && steer_oe && !seq_chain4_in && !host_a0
        |-> we[1] == 1'b0 && we[3] == 1'b0;
    endproperty
    a_oe_even: assert property (p_oe_even) // RULE8
        else $error("even address reached an odd map");

    property p_rsvd;
        io_req_in.rd && io_req_in.sel && st_reg.idx == IDX_ROT
        |=> io_rdata_out[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) // RULE27
        else $error("reserved bits not zero");

    property p_window;
        st_reg.r_misc[3:2] == 2'b10 && mem_req_in.wr
        && mem_req_in.addr[19:16] == 4'ha |-> we == 4'h0;
    endproperty
    a_window: assert property (p_window) // RULE17
        else $error("write outside window accepted");

    c_cmp_read: cover property (mem_req_in.rd && hit
        && st_reg.r_mode[MODE_RDCMP] ##2 mem_rvalid_out);
    c_mode3: cover property (we != 4'h0 && wmode == PGD_WM3);
    c_vid_256: cover property (vid_load_in && st_reg.r_mode[MODE_256]
                               ##2 vid_shift_in);

endmodule

// ---- hw/pgd_pkg.sv ----
// Purpose: shared constants and carriers for the planar graphics datapath
// Assumes: 8-bit host data bus, 20-bit host memory address
// Notes:   register indices, field positions, windows, reset values
package pgd_pkg;

    // Register indices selected through the index port
    localparam logic [3:0] IDX_SET_RST = 4'h0;
    localparam logic [3:0] IDX_EN_SR   = 4'h1;
    localparam logic [3:0] IDX_CMP     = 4'h2;
    localparam logic [3:0] IDX_ROT     = 4'h3;
    localparam logic [3:0] IDX_RMAP    = 4'h4;
    localparam logic [3:0] IDX_MODE    = 4'h5;
    localparam logic [3:0] IDX_MISC    = 4'h6;
    localparam logic [3:0] IDX_DC      = 4'h7;
    localparam logic [3:0] IDX_MASK    = 4'h8;

    // Writable bits per register; everything else reads zero
    localparam logic [7:0] WMSK_NIB    = 8'h0f;
    localparam logic [7:0] WMSK_ROT    = 8'h1f;
    localparam logic [7:0] WMSK_RMAP   = 8'h03;
    localparam logic [7:0] WMSK_MODE   = 8'h7b;
    localparam logic [7:0] WMSK_FULL   = 8'hff;
    localparam logic [7:0] RST_REG     = 8'h00;

    // Field positions
    localparam int ROT_LSB     = 0;
    localparam int OP_LSB      = 3;
    localparam int WM_LSB      = 0;
    localparam int MODE_RDCMP  = 3;
    localparam int MODE_OE     = 4;
    localparam int MODE_SHIFT  = 5;
    localparam int MODE_256    = 6;
    localparam int MISC_GFX    = 0;
    localparam int MISC_OE     = 1;
    localparam int MISC_WIN    = 2;

    // Host window bounds, upper bound exclusive
    localparam logic [19:0] WIN_A0000  = 20'ha0000;
    localparam logic [19:0] WIN_B0000  = 20'hb0000;
    localparam logic [19:0] WIN_B8000  = 20'hb8000;
    localparam logic [19:0] WIN_C0000  = 20'hc0000;

    // Edges from a taken host read to its answer
    localparam int RD_LAT = 2;

    typedef enum logic [1:0] {PGD_WM0, PGD_WM1, PGD_WM2, PGD_WM3} pgd_wmode_e;
    typedef enum logic [1:0] {PGD_OP_PASS, PGD_OP_AND, PGD_OP_OR,
                              PGD_OP_XOR} pgd_op_e;
    typedef enum logic [1:0] {PGD_WIN_128K, PGD_WIN_64K, PGD_WIN_MONO,
                              PGD_WIN_COLOR} pgd_win_e;

    // Register port access: sel 0 is index port, sel 1 is data port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       sel;
        logic [7:0] wdata;
    } pgd_io_req_s;

    // Host display memory cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } pgd_mem_req_s;

endpackage

// ---- hw/pgd_plane_mem.sv ----
// Purpose: four 8-bit display memory maps, host port and video port
// Assumes: one host access per cycle, byte write enable per map
// Notes:   read data of both ports come out of registers
`timescale 1ns/1ps
module pgd_plane_mem #(
    parameter int AW = 16
) (
    input  wire logic          mclk_in,
    input  wire logic [AW-1:0] a_addr_in,
    input  wire logic [3:0]    a_we_in,
    input  wire logic [31:0]   a_wdata_in,
    output logic      [31:0]   a_rdata_out,
    input  wire logic [AW-1:0] b_addr_in,
    output logic      [31:0]   b_rdata_out
);
    // Array kept unpacked so it maps to RAM; no reset on contents
    logic [31:0] mem_arr [2**AW];

    // Per-map byte write; one process so the array has a single driver
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (a_we_in[i]) begin
                mem_arr[a_addr_in][8*i +: 8] <= a_wdata_in[8*i +: 8];
            end
        end
    end

    // Registered reads, old data on a same-address write
    always_ff @(posedge mclk_in) begin
        a_rdata_out <= mem_arr[a_addr_in];
        b_rdata_out <= mem_arr[b_addr_in];
    end

endmodule

// ---- dv/pgd_host_model.sv ----
// Purpose: host processor model for register and memory cycles
// Assumes: strobes launched 1 ns after a rising edge
// Notes:   released buses show inverted data so stale values never pass
`timescale 1ns/1ps
module pgd_host_model
    import pgd_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rvalid_in,
    input  wire logic [7:0]       rdata_in,
    output pgd_pkg::pgd_io_req_s  io_req_out,
    output pgd_pkg::pgd_mem_req_s mem_req_out
);
    initial io_req_out = '0;
    initial mem_req_out = '0;
    // Register port cycle: one access at port s for one edge, then release
    task automatic io(input logic s, input logic w, input logic [7:0] d);
        @(posedge mclk_in);
        #1 io_req_out = {w, ~w, s, d};
        @(posedge mclk_in);
        #1 io_req_out = {2'b00, ~s, ~d};
    endtask
    // Memory cycle; a read waits a bounded time for its answer
    task automatic mem(input logic w, input logic [19:0] a,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
        ok = 1'b0;
        q = 8'h00;
        @(posedge mclk_in);
        #1 mem_req_out = {w, ~w, a, d};
        @(posedge mclk_in);
        #1 mem_req_out = {2'b00, ~a, ~d};
        if (!w) begin
            repeat (3) begin
                @(posedge mclk_in);
                #1;
                if (rvalid_in && !ok) begin
                    ok = 1'b1;
                    q = rdata_in;
                end
            end
        end
    endtask
endmodule

// ---- dv/tb_pgd_datapath.sv ----
// Purpose: self-checking bench for the planar graphics datapath
// Assumes: all maps write-enabled
// Notes:   maps are read back one by one through the read-map field
`timescale 1ns/1ps
module tb_pgd_datapath;
    import pgd_pkg::*;
    localparam logic [19:0] A = 20'ha0010;
    localparam logic [19:0] B = 20'ha0020;
    logic         mclk_in = 1'b0;
    logic         rst_n_in = 1'b0;
    pgd_io_req_s  io_req;
    pgd_mem_req_s mem_req;
    logic [7:0]   io_rdata;
    logic         rvalid;
    logic [7:0]   rdata;
    logic         gfx;
    logic         c4 = 1'b0;
    logic         vld = 1'b0;
    logic         vsh = 1'b0;
    logic [3:0]   pix;
    logic         p256;
    int           n_fail = 0;
    int           total_checks = 0;
    int           cyc = 0;

    always #4 mclk_in = ~mclk_in;

    pgd_datapath DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .io_req_in(io_req), .io_rdata_out(io_rdata), .mem_req_in(mem_req),
        .mem_rvalid_out(rvalid), .mem_rdata_out(rdata),
        .seq_chain4_in(c4), .plane_wr_en_in(4'hf), .vid_load_in(vld),
        .vid_shift_in(vsh), .vid_addr_in(16'h0010), .pixel_out(pix),
        .pixel_256_out(p256), .gfx_mode_out(gfx));
    pgd_host_model host (.mclk_in(mclk_in), .rvalid_in(rvalid),
        .rdata_in(rdata), .io_req_out(io_req), .mem_req_out(mem_req));

    // Shared compare; counts every check
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        host.io(1'b0, 1'b1, {4'h0, i});
        host.io(1'b1, 1'b1, d);
    endtask
    task automatic rreg(input logic [3:0] i, input logic [7:0] e);
        host.io(1'b0, 1'b1, {4'h0, i});
        host.io(1'b1, 1'b0, 8'h00);
        chk(io_rdata, e);
    endtask
    task automatic mrd(input logic [19:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic       ok;
        host.mem(1'b0, a, 8'h00, q, ok);
        chk({7'h0, ok}, 8'h01);
        chk(q, e);
    endtask
    task automatic mwr(input logic [19:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ok;
        host.mem(1'b1, a, d, q, ok);
    endtask
    // Map i expected in e[8i+7:8i]
    task automatic maps(input logic [19:0] a, input logic [31:0] e);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_RMAP, 8'(i));
            mrd(a, e[8*i +: 8]);
        end
    endtask

    task automatic t_regs();
        logic [7:0] m [6] = '{WMSK_ROT, WMSK_RMAP, WMSK_MODE,
                              WMSK_NIB, WMSK_NIB, WMSK_FULL};
        for (int i = 0; i < 6; i++) begin
            rreg(4'(i + 3), RST_REG);
            wr(4'(i + 3), 8'hff);
            rreg(4'(i + 3), m[i]);
        end
        chk({7'h0, gfx}, 8'h01);
        for (int i = 0; i < 6; i++)
            wr(4'(i + 3), 8'h00);
        $display("test regs done");
    endtask
    task automatic t_write();
        wr(IDX_MASK, 8'hff);
        wr(IDX_ROT, 8'h03);
        mwr(A, 8'h01);
        maps(A, {4{8'h20}});
        // Latches now hold 20 in every map: change masked bits only
        wr(IDX_ROT, 8'h18);
        wr(IDX_MASK, 8'h0f);
        mwr(A, 8'h33);
        maps(A, {4{8'h23}});
        wr(IDX_ROT, 8'h10);
        wr(IDX_MASK, 8'hf0);
        mwr(A, 8'h40);
        maps(A, {4{8'h63}});
        $display("test write done");
    endtask
    task automatic t_modes();
        wr(IDX_ROT, 8'h00);
        wr(IDX_MASK, 8'hff);
        wr(IDX_MODE, 8'h02);
        mwr(A, 8'h05);
        maps(A, 32'h00ff00ff);
        wr(IDX_MODE, 8'h01);
        mwr(B, 8'h00);
        maps(B, 32'h00ff00ff);
        wr(IDX_SET_RST, 8'h03);
        wr(IDX_EN_SR, 8'h05);
        wr(IDX_MODE, 8'h00);
        mwr(B, 8'h3c);
        maps(B, 32'h3c003cff);
        wr(IDX_MODE, 8'h03);
        wr(IDX_MASK, 8'h0f);
        mwr(B, 8'h55);
        maps(B, 32'h38003dff);
        $display("test modes done");
    endtask
    task automatic t_cmp();
        logic [7:0] q;
        logic       ok;
        wr(IDX_MODE, 8'h08);
        wr(IDX_CMP, 8'h05);
        wr(IDX_DC, 8'h0f);
        mrd(A, 8'hff);
        wr(IDX_CMP, 8'h00);
        wr(IDX_DC, 8'h02);
        mrd(A, 8'hff);
        wr(IDX_DC, 8'h01);
        mrd(A, 8'h00);
        wr(IDX_MODE, 8'h00);
        wr(IDX_MISC, 8'h04);
        host.mem(1'b0, 20'hb0010, 8'h00, q, ok);
        chk({7'h0, ok}, 8'h00);
        wr(IDX_MISC, 8'h08);
        host.mem(1'b0, A, 8'h00, q, ok);
        chk({7'h0, ok}, 8'h00);
        mwr(A, 8'h00);
        $display("test compare and window done");
    endtask
    // Video fetch at map address 10: load, then four dot shifts
    task automatic t_vid(input logic [7:0] m, input logic [3:0] e0,
                         input logic [3:0] e4);
        wr(IDX_MODE, m);
        vld = 1'b1;
        @(posedge mclk_in);
        #1 vld = 1'b0;
        @(posedge mclk_in);
        #1 chk({p256, 3'h0, pix}, {m[6], 3'h0, e0});
        vsh = 1'b1;
        repeat (4) @(posedge mclk_in);
        #1 vsh = 1'b0;
        chk({4'h0, pix}, {4'h0, e4});
        $display("test video done");
    endtask
    task automatic t_oe();
        wr(IDX_MASK, 8'hff);
        wr(IDX_MODE, 8'h02);
        wr(IDX_MISC, 8'h02);
        mwr(20'ha0041, 8'h07);
        mwr(20'ha0040, 8'h01);
        wr(IDX_MISC, 8'h00);
        maps(20'ha0040, 32'h0000ffff);
        wr(IDX_MODE, 8'h10);
        wr(IDX_MISC, 8'h02);
        wr(IDX_RMAP, 8'h00);
        mrd(20'ha0041, 8'hff);
        c4 = 1'b1;
        mrd(20'ha0042, 8'hff);
        c4 = 1'b0;
        $display("test odd/even done");
    endtask

    task automatic summarize();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard: the whole run needs well under 3000 cycles
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        t_regs();
        t_write();
        t_modes();
        t_vid(8'h00, 4'h5, 4'h5);
        t_vid(8'h20, 4'hf, 4'h0);
        t_vid(8'h60, 4'hf, 4'hf);
        t_cmp();
        t_oe();
        summarize();
    end
endmodule
